// ==== hw/stw_pkg.sv ====
`default_nettype none
package stw_pkg;

  // Operating mode field encodings
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SYNC = 3'h1;
  localparam logic [2:0] MODE_ASYNC7 = 3'h4;
  localparam logic [2:0] MODE_ASYNC8 = 3'h5;
  localparam logic [2:0] MODE_ASYNC9 = 3'h6;

  // Character lengths of the asynchronous modes
  localparam logic [3:0] CHAR_LEN7 = 4'h7;
  localparam logic [3:0] CHAR_LEN8 = 4'h8;
  localparam logic [3:0] CHAR_LEN9 = 4'h9;

  // Divider limits and detection timing, in count-source cycles
  localparam logic [7:0] DIV_MIN = 8'h03;
  localparam logic [3:0] COND_MIN_CYC = 4'h6;
  localparam logic [7:0] DIV_RESET = 8'h03;

  typedef struct packed {
    logic start_req;
    logic restart_req;
    logic stop_req;
    logic gen_sel;
    logic scl_release;
  } stw_master_ctl_t;

  typedef struct packed {
    logic ack_data;
    logic ack_ctl;
    logic ninth_hold;
  } stw_slave_ctl_t;

  typedef struct packed {
    logic two_wire;
    logic clk_phase;
    logic [2:0] data_delay;
  } stw_cfg_t;

endpackage : stw_pkg
`default_nettype wire

// ==== hw/stw_buf2.sv ====
`timescale 1ns/1ns
`default_nettype none
// Two-entry buffer with valid/ready on both sides
module stw_buf2 #(
  parameter int WIDTH = 9
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_i;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  // Data out of a register: the head entry is itself a flop
  assign out_data_o = mem_r[rp_r];
endmodule : stw_buf2
`default_nettype wire

// ==== hw/stw_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module stw_core #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Channel control
  input wire logic [2:0] operating_mode_field_i,
  input wire logic transmit_enable_bit_i,
  input wire logic receive_enable_bit_i,
  input wire logic [DIV_W-1:0] baud_divider_i,
  input wire stw_pkg::stw_cfg_t cfg_i,
  input wire stw_pkg::stw_master_ctl_t master_ctl_i,
  input wire stw_pkg::stw_slave_ctl_t slave_ctl_i,
  // Transmit buffer write port
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic [8:0] tx_data_i,
  // Status
  output logic channel_on_o,
  output logic [3:0] char_len_o,
  output logic transmit_buffer_empty_flag_o,
  output logic transmit_shifter_empty_o,
  output logic slave_tx_start_o,
  output logic slave_rx_start_o,
  output logic cond_irq_o,
  output logic bus_condition_flag_o,
  output logic req_done_o,
  // Two-wire pins
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_o,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  typedef enum logic [1:0] {STW_OFF, STW_SYNC, STW_ASYNC} stw_mode_t;
  stw_mode_t mode_w;
  assign mode_w = (operating_mode_field_i == stw_pkg::MODE_SYNC) ? STW_SYNC :
      (operating_mode_field_i == stw_pkg::MODE_ASYNC7 ||
       operating_mode_field_i == stw_pkg::MODE_ASYNC8 ||
       operating_mode_field_i == stw_pkg::MODE_ASYNC9) ? STW_ASYNC :
      STW_OFF;
  wire chan_on = (mode_w != STW_OFF);
  assign channel_on_o = chan_on;
  assign char_len_o =
      (operating_mode_field_i == stw_pkg::MODE_ASYNC7) ? stw_pkg::CHAR_LEN7 :
      (operating_mode_field_i == stw_pkg::MODE_ASYNC8) ? stw_pkg::CHAR_LEN8 :
      (operating_mode_field_i == stw_pkg::MODE_ASYNC9) ? stw_pkg::CHAR_LEN9 :
      4'h0;
  // Two-wire logic runs in any live channel, sync or async, once two-wire is selected
  wire iic_on = chan_on && cfg_i.two_wire;
  // Mode-four bits are ignored unless two-wire is selected
  wire gen_sel = iic_on && master_ctl_i.gen_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: three flops, change accepted when 2nd and 3rd agree
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_f_r;
  logic sda_f_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], serial_clock_line_i};
      sda_s_r <= {sda_s_r[1:0], serial_data_line_i};
      if (scl_s_r[1] == scl_s_r[2]) scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_f_r <= sda_s_r[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition detection with six-cycle setup qualification (SCL high, SDA steady before the edge)
  logic [3:0] hi_cnt_r;
  logic sda_prev_r;
  logic det_start_r;
  logic det_stop_r;
  wire hi_ok = (hi_cnt_r >= stw_pkg::COND_MIN_CYC);
  wire sda_fall = sda_prev_r && !sda_f_r;
  wire sda_rise = !sda_prev_r && sda_f_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hi_cnt_r <= 4'h0;
      sda_prev_r <= 1'b1;
      det_start_r <= 1'b0;
      det_stop_r <= 1'b0;
    end else begin
      sda_prev_r <= sda_f_r;
      // Count SCL-high cycles with SDA steady; an SDA edge restarts it
      if (!scl_f_r || sda_fall || sda_rise) hi_cnt_r <= 4'h0;
      else if (!hi_ok) hi_cnt_r <= hi_cnt_r + 4'h1;
      det_start_r <= iic_on && scl_f_r && sda_fall && hi_ok;
      det_stop_r <= iic_on && scl_f_r && sda_rise && hi_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // SCL divider: half period of (divider + 1) source cycles
  logic [DIV_W-1:0] div_cnt_r;
  logic half_tick_r;
  // Values under 03h would outrun the three-cycle SCL sampling
  wire [DIV_W-1:0] div_eff = (baud_divider_i < stw_pkg::DIV_MIN[DIV_W-1:0])
      ? stw_pkg::DIV_MIN[DIV_W-1:0] : baud_divider_i;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_cnt_r <= '0;
      half_tick_r <= 1'b0;
    end else if (div_cnt_r >= div_eff) begin
      div_cnt_r <= '0;
      half_tick_r <= 1'b1;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
      half_tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Condition generator
  typedef enum logic [2:0] {
    GEN_IDLE, GEN_ST_HOLD, GEN_ST_DONE, GEN_RS_SETUP, GEN_SP_LOW,
    GEN_SP_HOLD, GEN_SP_DONE
  } stw_gen_st_t;
  stw_gen_st_t gen_r;
  stw_gen_st_t gen_nxt;
  logic scl_drv_r;
  logic sda_drv_r;
  logic scl_nxt;
  logic sda_nxt;
  logic done_nxt;
  logic done_r;
  logic busy_r;

  always_comb begin
    gen_nxt = gen_r;
    scl_nxt = scl_drv_r;
    sda_nxt = sda_drv_r;
    done_nxt = 1'b0;
    case (gen_r)
      GEN_IDLE: begin
        if (gen_sel && half_tick_r) begin
          if (master_ctl_i.start_req) begin
            sda_nxt = 1'b0;
            gen_nxt = GEN_ST_HOLD;
          end else if (master_ctl_i.restart_req) begin
            sda_nxt = 1'b1;
            scl_nxt = 1'b1;
            gen_nxt = GEN_RS_SETUP;
          end else if (master_ctl_i.stop_req) begin
            sda_nxt = 1'b0;
            scl_nxt = 1'b0;
            gen_nxt = GEN_SP_LOW;
          end
        end
      end
      GEN_RS_SETUP: begin
        if (half_tick_r) begin
          sda_nxt = 1'b0;
          gen_nxt = GEN_ST_HOLD;
        end
      end
      GEN_ST_HOLD: begin
        // SDA low for one half period, then the first SCL fall
        if (half_tick_r) begin
          scl_nxt = 1'b0;
          gen_nxt = GEN_ST_DONE;
        end
      end
      GEN_ST_DONE: begin
        done_nxt = 1'b1;
        gen_nxt = GEN_IDLE;
      end
      GEN_SP_LOW: begin
        if (half_tick_r) begin
          scl_nxt = 1'b1;
          gen_nxt = GEN_SP_HOLD;
        end
      end
      GEN_SP_HOLD: begin
        // SCL high for one half period before SDA goes high
        if (half_tick_r) begin
          sda_nxt = 1'b1;
          gen_nxt = GEN_SP_DONE;
        end
      end
      GEN_SP_DONE: begin
        done_nxt = 1'b1;
        gen_nxt = GEN_IDLE;
      end
      default: begin
        gen_nxt = GEN_IDLE;
      end
    endcase
    // Leaving two-wire mode drops any condition in flight
    if (!iic_on) begin
      gen_nxt = GEN_IDLE;
      scl_nxt = 1'b1;
      sda_nxt = 1'b1;
      done_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gen_r <= GEN_IDLE;
      scl_drv_r <= 1'b1;
      sda_drv_r <= 1'b1;
      done_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      gen_r <= gen_nxt;
      scl_drv_r <= scl_nxt;
      sda_drv_r <= sda_nxt;
      done_r <= done_nxt;
      // Busy from start completion to stop completion or detection
      if (done_nxt && gen_r == GEN_ST_DONE) busy_r <= 1'b1;
      else if (done_nxt || det_stop_r) busy_r <= 1'b0;
      else if (det_start_r) busy_r <= 1'b1;
    end
  end
  assign req_done_o = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // SDA digital delay line
  logic [7:0] sda_dly_r;
  // The count is fixed at the tap, so a delay of n stays n (n+1 with sampling)
  wire sda_tap = (cfg_i.data_delay == 3'h0) ? sda_drv_r
      : sda_dly_r[cfg_i.data_delay - 3'h1];
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) sda_dly_r <= 8'hFF;
    else sda_dly_r <= {sda_dly_r[6:0], sda_drv_r};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins: open drain, driven only when pulling low, in generator mode or for the SCL ninth-bit hold
  logic scl_oe_r;
  logic sda_oe_r;
  logic scl_hold_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      scl_hold_r <= 1'b0;
    end else begin
      // Ninth-bit hold keeps SCL low in slave use while clk_phase is set
      scl_hold_r <= iic_on && !master_ctl_i.gen_sel &&
          slave_ctl_i.ninth_hold && cfg_i.clk_phase;
      // Release on stop detection when asked
      if (master_ctl_i.scl_release && det_stop_r) scl_oe_r <= 1'b0;
      else scl_oe_r <= (gen_sel && !scl_drv_r) || scl_hold_r;
      sda_oe_r <= gen_sel && !sda_tap;
    end
  end
  assign serial_clock_line_o = 1'b0;
  assign serial_data_line_o = 1'b0;
  assign serial_clock_line_oe_o = scl_oe_r;
  assign serial_data_line_oe_o = sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: detection when unselected, completion when selected
  logic irq_r;
  logic bbs_r;
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_r <= 1'b0;
      bbs_r <= 1'b0;
    end else begin
      irq_r <= gen_sel ? done_r : (det_start_r || det_stop_r);
      if (gen_sel ? done_r : det_start_r || det_stop_r)
        bbs_r <= gen_sel ? busy_r : det_start_r;
    end
  end
  assign cond_irq_o = irq_r;
  assign bus_condition_flag_o = bbs_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer and slave start qualification
  logic buf_valid;
  logic [8:0] buf_data;
  logic shift_empty_r;
  logic [8:0] shift_r;
  logic tx_go_r;
  logic rx_go_r;
  wire tx_ready_q = transmit_enable_bit_i && buf_valid;
  wire rx_ready_q = receive_enable_bit_i && tx_ready_q;
  wire slave_act = iic_on && !master_ctl_i.gen_sel;
  wire load = slave_act && tx_ready_q && shift_empty_r;

  stw_buf2 #(.WIDTH(9)) u_txbuf (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(buf_valid),
    .out_ready_i(load),
    .out_data_o(buf_data)
  );

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_empty_r <= 1'b1;
      shift_r <= 9'h000;
      tx_go_r <= 1'b0;
      rx_go_r <= 1'b0;
    end else begin
      // Disabling the channel or transmit only marks the shifter empty; buffer and shifter data stay
      if (!chan_on || !transmit_enable_bit_i) begin
        shift_empty_r <= 1'b1;
      end else if (load) begin
        shift_r <= buf_data;
        shift_empty_r <= 1'b0;
      end else if (det_stop_r) begin
        shift_empty_r <= 1'b1;
      end
      tx_go_r <= load;
      rx_go_r <= load && rx_ready_q;
    end
  end
  assign transmit_buffer_empty_flag_o = !buf_valid;
  assign transmit_shifter_empty_o = shift_empty_r;
  assign slave_tx_start_o = tx_go_r;
  assign slave_rx_start_o = rx_go_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_start_hold;
    gen_r == GEN_ST_HOLD && half_tick_r;
  endsequence

  a_mode_off_idle: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      operating_mode_field_i == stw_pkg::MODE_OFF |-> !channel_on_o)
    else $error("channel on in off mode");
  a_char_len_nine: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      operating_mode_field_i == stw_pkg::MODE_ASYNC9 |-> char_len_o == 4'h9)
    else $error("wrong character length");
  a_start_scl_fall: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      (s_start_hold and iic_on) |=> !scl_drv_r && !sda_drv_r)
    else $error("start scl fall wrong");
  a_stop_sda_rise: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      gen_r == GEN_SP_HOLD && half_tick_r && iic_on |=> sda_drv_r && scl_drv_r)
    else $error("stop sda rise wrong");
  a_start_detect: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      det_start_r && !gen_sel |=> cond_irq_o && bus_condition_flag_o)
    else $error("start detect irq missing");
  a_stop_detect: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      det_stop_r && !gen_sel |=> cond_irq_o && !bus_condition_flag_o)
    else $error("stop detect irq missing");
  a_tx_start_qual: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      slave_tx_start_o |-> $past(transmit_enable_bit_i) && $past(buf_valid))
    else $error("tx start without enable");
  a_rx_start_qual: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      slave_rx_start_o |-> $past(receive_enable_bit_i))
    else $error("rx start without enable");
  a_done_irq_sel: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      req_done_o && gen_sel |=> cond_irq_o)
    else $error("completion irq missing");
  a_half_period: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      half_tick_r && $stable(baud_divider_i) |=> !half_tick_r [*3])
    else $error("half period too short");
endmodule : stw_core
`default_nettype wire

// ==== test/stw_bus_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module stw_bus_model (
  // Device side of the open-drain lines
  input wire logic scl_oe_i,
  input wire logic sda_oe_i,
  // Resolved line levels
  output logic scl_o,
  output logic sda_o
);
  localparam int HALF_NS = 80;
  logic scl_pull_r;
  logic sda_pull_r;
  // Pull-ups: a line nobody pulls reads high, never a stale value
  assign scl_o = !(scl_oe_i || scl_pull_r);
  assign sda_o = !(sda_oe_i || sda_pull_r);
  initial begin
    scl_pull_r = 1'b0;
    sda_pull_r = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Start, eight bits, stop; SCL stands still high between frames.
  // Never sends a restart to the device.
  task automatic frame(input logic [7:0] bits);
    // Offset keeps every line change clear of the system clock edge
    #(HALF_NS + 3);
    sda_pull_r = 1'b1;
    #HALF_NS;
    for (int i = 7; i >= 0; i--) begin
      scl_pull_r = 1'b1;
      #(HALF_NS / 2);
      sda_pull_r = !bits[i];
      #(HALF_NS / 2);
      scl_pull_r = 1'b0;
      #HALF_NS;
    end
    scl_pull_r = 1'b1;
    #(HALF_NS / 2);
    sda_pull_r = 1'b1;
    #(HALF_NS / 2);
    scl_pull_r = 1'b0;
    // Eight count-source cycles of setup, above the six needed
    #HALF_NS;
    sda_pull_r = 1'b0;
    #HALF_NS;
  endtask : frame
endmodule : stw_bus_model
`default_nettype wire

// ==== test/testbench.sv ====
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys;
  logic arst_n;
  logic [2:0] mode;
  logic te;
  logic re;
  logic [7:0] div;
  stw_pkg::stw_cfg_t cfg;
  stw_pkg::stw_master_ctl_t mctl;
  stw_pkg::stw_slave_ctl_t sctl;
  logic tx_valid;
  logic tx_ready;
  logic [8:0] tx_data;
  logic chan_on;
  logic [3:0] char_len;
  logic tbe;
  logic tse;
  logic stx;
  logic srx;
  logic irq;
  logic bflag;
  logic done;
  logic scl_oe;
  logic sda_oe;
  wire scl;
  wire sda;
  logic sda_oe_q;
  logic scl_oe_q;
  logic irq_q;
  logic [1:0] hist;
  int cyc = 0;
  int irq_cnt = 0;
  int done_cnt = 0;
  int stx_cnt = 0;
  int srx_cnt = 0;
  int oe_cnt = 0;
  int t_sda_r = 0;
  int t_sda_f = 0;
  int t_scl_r = 0;
  int t_scl_f = 0;
  int fail_count = 0;
  int checked = 0;
  logic [31:0] rnd = 32'h6391;

  stw_core stw_core_inst (
    .clk_sys_i(clk_sys), .arst_n_i(arst_n),
    .operating_mode_field_i(mode), .transmit_enable_bit_i(te),
    .receive_enable_bit_i(re), .baud_divider_i(div), .cfg_i(cfg),
    .master_ctl_i(mctl), .slave_ctl_i(sctl), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .tx_data_i(tx_data), .channel_on_o(chan_on),
    .char_len_o(char_len), .transmit_buffer_empty_flag_o(tbe),
    .transmit_shifter_empty_o(tse), .slave_tx_start_o(stx),
    .slave_rx_start_o(srx), .cond_irq_o(irq), .bus_condition_flag_o(bflag),
    .req_done_o(done), .serial_clock_line_i(scl), .serial_clock_line_o(),
    .serial_clock_line_oe_o(scl_oe), .serial_data_line_i(sda),
    .serial_data_line_o(), .serial_data_line_oe_o(sda_oe));

  stw_bus_model stw_bus_model_inst (
    .scl_oe_i(scl_oe), .sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Edge times and pulse counts, so one-cycle pulses are never missed
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sda_oe_q <= sda_oe;
    scl_oe_q <= scl_oe;
    irq_q <= irq;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (done === 1'b1) done_cnt <= done_cnt + 1;
    if (stx === 1'b1) stx_cnt <= stx_cnt + 1;
    if (srx === 1'b1) srx_cnt <= srx_cnt + 1;
    if (sda_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    if (irq_q === 1'b1) hist <= {hist[0], bflag};
    if (sda_oe === 1'b1 && sda_oe_q === 1'b0) t_sda_r <= cyc;
    if (sda_oe === 1'b0 && sda_oe_q === 1'b1) t_sda_f <= cyc;
    if (scl_oe === 1'b1 && scl_oe_q === 1'b0) t_scl_r <= cyc;
    if (scl_oe === 1'b0 && scl_oe_q === 1'b1) t_scl_f <= cyc;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [3:0] exp_len(input logic [2:0] m);
    return (m == 3'h4) ? 4'h7 : (m == 3'h5) ? 4'h8 : (m == 3'h6) ? 4'h9 : 4'h0;
  endfunction : exp_len

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  task automatic stop_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // Request bit first, then the generator select; clear after completion
  task automatic gen(input int kind);
    int i0;
    int d0;
    int k;
    i0 = irq_cnt;
    d0 = done_cnt;
    tick(1);
    mctl.start_req <= (kind == 0);
    mctl.restart_req <= (kind == 1);
    mctl.stop_req <= (kind == 2);
    tick(1);
    mctl.gen_sel <= 1'b1;
    k = 0;
    while (done_cnt == d0 && k < 500) begin
      tick(1);
      k++;
    end
    mctl.start_req <= 1'b0;
    mctl.restart_req <= 1'b0;
    mctl.stop_req <= 1'b0;
    // Select held on so our own condition is not reported as detected
    tick(20);
    mctl.gen_sel <= 1'b0;
    tick(2);
    check("done pulses", 1, done_cnt - d0);
    check("irq on completion", 1, irq_cnt - i0);
  endtask : gen

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n;
    int d;
    int acc;
    int exp_on;
    arst_n = 1'b0;
    mode = 3'h0;
    te = 1'b0;
    re = 1'b0;
    div = 8'h03;
    cfg = '0;
    mctl = '0;
    sctl = '0;
    tx_valid = 1'b0;
    tx_data = 9'h000;
    tick(12);
    arst_n <= 1'b1;
    // Shut-down and re-init sequence through every mode code
    for (int m = 0; m < 8; m++) begin
      tick(1);
      te <= 1'b0;
      re <= 1'b0;
      tick(1);
      mode <= 3'h0;
      tick(2);
      check("channel off", 0, chan_on);
      mode <= m[2:0];
      tick(1);
      te <= 1'b1;
      re <= 1'b1;
      tick(2);
      // Only the sync and the three async codes switch the channel on
      exp_on = (m == 1) || (exp_len(m[2:0]) != 4'h0);
      check("channel on", exp_on, chan_on);
      check("char len", exp_len(m[2:0]), char_len);
    end
    te <= 1'b0;
    re <= 1'b0;
    mode <= stw_pkg::MODE_SYNC;
    cfg.two_wire <= 1'b1;
    cfg.clk_phase <= 1'b1;
    rnd = lfsr(rnd);
    // Ninth-bit hold stays off here: it would pin SCL low in slave use
    sctl <= {rnd[2:1], 1'b0};
    // A request without the select must not drive SDA (only the SDA enable is counted)
    tick(2);
    mctl.start_req <= 1'b1;
    tick(50);
    check("no oe unselected", 0, oe_cnt);
    mctl.start_req <= 1'b0;
    sctl.ninth_hold <= 1'b1;
    tick(4);
    check("ninth hold", 1, scl_oe);
    sctl.ninth_hold <= 1'b0;
    tick(4);
    check("ninth release", 0, scl_oe);
    // Generator timing: divider boundary, random divider, data delay
    for (int j = 0; j < 3; j++) begin
      rnd = lfsr(rnd);
      n = (j == 0) ? 3 : 6 + rnd[2:0];
      d = (j == 2) ? 5 : 0;
      div <= n[7:0];
      cfg.data_delay <= d[2:0];
      tick(4);
      gen(0);
      check("start hold", n + 1 - d,
            t_scl_r - t_sda_r);
      check("busy after start", 1, bflag);
      gen(1);
      gen(2);
      check("stop setup", n + 1 + d,
            t_sda_f - t_scl_f);
    end
    // Detection of an outside frame, data toggling while SCL low
    acc = irq_cnt;
    rnd = lfsr(rnd);
    stw_bus_model_inst.frame(rnd[7:0]);
    tick(10);
    check("detect irqs", 2, irq_cnt - acc);
    check("which condition", 2'b10, hist);
    // Slave starts: fill the buffer with transmit disabled
    acc = 0;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      tx_valid <= 1'b1;
      tx_data <= rnd[8:0];
      tick(1);
      if (tx_ready === 1'b1) acc++;
    end
    tx_valid <= 1'b0;
    tick(2);
    check("buffer depth", 2, acc);
    check("buffer holds", 0, tbe);
    check("no start yet", 0, stx_cnt);
    // External clock idles high while the last condition comes true
    te <= 1'b1;
    tick(10);
    check("tx start", 1, stx_cnt);
    check("no rx start", 0, srx_cnt);
    check("shifter full", 0, tse);
    te <= 1'b0;
    tick(3);
    re <= 1'b1;
    tick(3);
    te <= 1'b1;
    tick(10);
    check("tx start 2", 2, stx_cnt);
    check("rx start", 1, srx_cnt);
    check("buffer drained", 1, tbe);
    te <= 1'b0;
    tick(3);
    te <= 1'b1;
    tick(10);
    check("no data no start", 2, stx_cnt);
    stop_test();
  end

  initial begin
    #200000;
    fail_count++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire
